// >>> inc/kpi_consts.vh
// Constants for the keypad pin interrupt block: register offsets, bit positions, reset values.
// Assumes a 32-bit APB with byte addresses and one register per aligned word.
//
// Notes on behaviour
// - Detection and flag setting continue unchanged while the processor is halted in debug.
// - Status/control bits 7:4 read zero; writes to them do nothing.
// - Status bit 3 is the event flag; writes cannot change it directly.
// - Status bit 2 is a write-only acknowledge; writing 1 asks to clear the flag.
// - Status bit 1 enables the interrupt request when the flag is set.
// - Status bit 0 selects edges only (0) or edges and levels (1).
// - Each pin enable bit makes its pin a source; disabled pins are ignored.
// - Polarity bit 0 means falling edge/low level; 1 means rising edge/high level.
// - Falling edge: sampled high one bus cycle, low the next.
// - Rising edge: sampled low one bus cycle, high the next.
// - Edges count only after all enabled inputs were deasserted since the last edge.
// - A valid edge sets the flag; request raised if interrupt enable set.
// - In edge-and-level mode an asserted level also sets the flag.
// - In level mode acknowledge clears only when all enabled inputs are deasserted.
// - With pull enabled, polarity 0 selects pull-up; polarity 1 selects pull-down on enabled source pins and pull-up on the others.
// - Up to eight independent pin sources, usable as wake-up from wait or stop.
// - Leaving the deepest stop modes returns the block to its reset state.
`ifndef KPI_CONSTS_VH
`define KPI_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define KPI_ADDR_W        12
`define KPI_OFS_STATUS    12'h000
`define KPI_OFS_PIN_EN    12'h004
`define KPI_OFS_POLARITY  12'h008

// ****************************************************************
// Status/control fields
// ****************************************************************
`define KPI_BIT_MODE      0
`define KPI_BIT_IRQ_EN    1
`define KPI_BIT_ACK       2
`define KPI_BIT_FLAG      3

// ****************************************************************
// Reset values
// ****************************************************************
`define KPI_RST_BYTE      8'h00
`define KPI_RST_WORD      32'h00000000

`endif

// >>> logic/kpi_sync.v
// Two-stage synchroniser, one chain per bit.
// Assumes the inputs are asynchronous to pclk; only the second stage may be read.
`default_nettype none

module kpi_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // ****************************************************************
    // Per-bit chains
    // ****************************************************************
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> logic/kpi_top.v
// Keypad pin interrupt block: APB register slave, pin edge/level detection, event flag, request.
// Assumes pins are asynchronous to pclk; deep stop exit is signalled on the same clock.
//
// The APB register port and the address map were decided locally.
`include "kpi_consts.vh"
`default_nettype none

module kpi_top #(
    parameter NPINS = 8
) (
    // Clock and reset
    input  wire                   pclk,
    input  wire                   presetn,
    // APB slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`KPI_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    input  wire [3:0]             pstrb,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    // Pins and port pull control
    input  wire [NPINS-1:0]       keypad_input_pins,
    input  wire [NPINS-1:0]       port_pull_enable,
    output reg  [NPINS-1:0]       pull_up_en,
    output reg  [NPINS-1:0]       pull_down_en,
    // System
    input  wire                   deep_stop_wake,
    output reg                    irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [NPINS-1:0] pin_source_enable;
    reg  [NPINS-1:0] pin_polarity_select;
    reg              level_detect_select;
    reg              pin_irq_enable;
    reg              pin_event_flag;
    reg  [NPINS-1:0] prev_asserted;
    reg              armed;

    wire [NPINS-1:0] pin_sync;
    wire [NPINS-1:0] asserted_now;
    wire [NPINS-1:0] edge_hit;
    wire             any_asserted;
    wire             any_edge;
    wire             set_event;
    wire             wr_take;
    wire             rd_setup;
    wire             hit_status;
    wire             hit_pin_en;
    wire             hit_polarity;
    wire             hit_any;
    wire             ack_write;
    wire             clear_ok;
    wire [7:0]       status_byte;

    reg  [31:0]      next_prdata;
    reg              next_pready;
    reg              next_pslverr;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    kpi_sync #(
        .WIDTH    (NPINS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (keypad_input_pins),
        .sync_out (pin_sync)
    );

    // ****************************************************************
    // Detection
    // ****************************************************************
    // An enabled pin is asserted when its synchronised level equals its polarity bit
    assign asserted_now = pin_source_enable & ~(pin_sync ^ pin_polarity_select);

    // Edge: deasserted in the previous bus cycle, asserted in this one
    assign edge_hit     = asserted_now & ~prev_asserted & {NPINS{armed}};

    assign any_asserted = |asserted_now;
    assign any_edge     = |edge_hit;

    // Level mode adds any asserted level as a set source
    assign set_event    = any_edge | (level_detect_select & any_asserted);

    // Detection has no dependence on debug halt, so it keeps running then
    // Re-arm only once every enabled input is back at its deasserted level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_asserted <= {NPINS{1'b0}};
            armed         <= 1'b0;
        end else if (deep_stop_wake) begin
            prev_asserted <= {NPINS{1'b0}};
            armed         <= 1'b0;
        end else begin
            prev_asserted <= asserted_now;
            if (any_edge) begin
                armed <= 1'b0;
            end else if (!any_asserted) begin
                armed <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign wr_take      = psel & penable & pready & pwrite;
    assign rd_setup     = psel & ~penable & ~pwrite;
    assign hit_status   = (paddr == `KPI_OFS_STATUS);
    assign hit_pin_en   = (paddr == `KPI_OFS_PIN_EN);
    assign hit_polarity = (paddr == `KPI_OFS_POLARITY);
    assign hit_any      = hit_status | hit_pin_en | hit_polarity;

    // Only the low byte lane carries register bits
    assign ack_write    = wr_take & hit_status & pstrb[0] & pwdata[`KPI_BIT_ACK];

    // In level mode the clear is refused while any enabled pin is asserted
    assign clear_ok     = ~level_detect_select | ~any_asserted;

    // Upper nibble zero, acknowledge always reads zero
    assign status_byte  = {4'h0, pin_event_flag, 1'b0, pin_irq_enable, level_detect_select};

    // ****************************************************************
    // Registers written by software
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_source_enable   <= `KPI_RST_BYTE;
            pin_polarity_select <= `KPI_RST_BYTE;
            level_detect_select <= 1'b0;
            pin_irq_enable      <= 1'b0;
        end else if (deep_stop_wake) begin
            pin_source_enable   <= `KPI_RST_BYTE;
            pin_polarity_select <= `KPI_RST_BYTE;
            level_detect_select <= 1'b0;
            pin_irq_enable      <= 1'b0;
        end else if (wr_take && pstrb[0]) begin
            // Bits 7:4 have no storage, so writes there are dropped
            if (hit_status) begin
                level_detect_select <= pwdata[`KPI_BIT_MODE];
                pin_irq_enable      <= pwdata[`KPI_BIT_IRQ_EN];
            end else if (hit_pin_en) begin
                pin_source_enable   <= pwdata[NPINS-1:0];
            end else if (hit_polarity) begin
                pin_polarity_select <= pwdata[NPINS-1:0];
            end
        end
    end

    // ****************************************************************
    // Event flag
    // ****************************************************************
    // A new event in the acknowledge cycle wins, so no event is lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_event_flag <= 1'b0;
        end else if (deep_stop_wake) begin
            pin_event_flag <= 1'b0;
        end else if (set_event) begin
            pin_event_flag <= 1'b1;
        end else if (ack_write && clear_ok) begin
            pin_event_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt request and pull control
    // ****************************************************************
    // Request is a level; it follows the flag one cycle later and stays up with it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq          <= 1'b0;
            pull_up_en   <= {NPINS{1'b0}};
            pull_down_en <= {NPINS{1'b0}};
        end else begin
            irq          <= pin_event_flag & pin_irq_enable & ~deep_stop_wake;
            // Pull-down only replaces the pull-up on pins serving as sources
            pull_down_en <= port_pull_enable & pin_source_enable & pin_polarity_select;
            pull_up_en   <= port_pull_enable & ~(pin_source_enable & pin_polarity_select);
        end
    end

    // ****************************************************************
    // APB response
    // ****************************************************************
    // One wait state: read data is captured in setup, pready rises in the second access cycle
    always @* begin
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (rd_setup) begin
            if (hit_status) begin
                next_prdata = {24'h000000, status_byte};
            end else if (hit_pin_en) begin
                next_prdata = {{(32-NPINS){1'b0}}, pin_source_enable};
            end else if (hit_polarity) begin
                next_prdata = {{(32-NPINS){1'b0}}, pin_polarity_select};
            end else begin
                next_prdata = `KPI_RST_WORD;
            end
        end
        if (psel && penable && !pready) begin
            next_pready  = 1'b1;
            next_pslverr = ~hit_any;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `KPI_RST_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

`default_nettype wire

// >>> bench/kpi_asserts.sv
// Checker for the keypad pin interrupt top: APB timing, request output, pull outputs.
// Assumes it sees only the ports of kpi_top; bound at the foot of this file.
`include "kpi_consts.vh"
`default_nettype none
module kpi_asserts #(
    parameter NPINS = 8
) (
    // Clock, reset and APB
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`KPI_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Pulls and system
    input wire logic [NPINS-1:0]       port_pull_enable,
    input wire logic [NPINS-1:0]       pull_up_en,
    input wire logic [NPINS-1:0]       pull_down_en,
    input wire logic                   deep_stop_wake,
    input wire logic                   irq
);
    // ****************************************************************
    // Shadow of the request enable, kept from completed writes
    // ****************************************************************
    logic      ien;
    wire logic wst = psel && penable && pready && pwrite && paddr == `KPI_OFS_STATUS;
    wire logic rst_rd = pready && !pwrite && paddr == `KPI_OFS_STATUS;
    wire logic mapped = paddr == `KPI_OFS_STATUS || paddr == `KPI_OFS_PIN_EN || paddr == `KPI_OFS_POLARITY;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ien <= 1'b0;
        else if (deep_stop_wake)
            ien <= 1'b0;
        else if (wst && pstrb[0])
            ien <= pwdata[`KPI_BIT_IRQ_EN];
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    AST_SETUP_ANSWER: assert property (s_setup |=> s_answer)
        else $error("no answer in second access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address map");
    AST_UPPER_ZERO: assert property (rst_rd |-> prdata[31:4] == 28'h0000000)
        else $error("status upper bits not zero");
    AST_ACK_ZERO: assert property (rst_rd |-> !prdata[`KPI_BIT_ACK])
        else $error("acknowledge bit read as one");
    AST_IRQ_NEEDS_EN: assert property (irq |-> $past(ien))
        else $error("request raised while masked");
    AST_IRQ_HOLDS: assert property (irq && !wst && !$past(wst) && !deep_stop_wake
        && !$past(deep_stop_wake) |=> irq)
        else $error("request dropped without cause");
    AST_DSW_CLEAR: assert property (deep_stop_wake |-> ##2 !irq)
        else $error("request survives deep stop exit");
    AST_PULL_TRACK: assert property ($past(presetn) && !$past(deep_stop_wake)
        |-> (pull_up_en | pull_down_en) == $past(port_pull_enable))
        else $error("pull outputs do not follow pull enables");
    AST_PULL_EXCL: assert property ((pull_up_en & pull_down_en) == '0)
        else $error("pull-up and pull-down both on");
endmodule
bind kpi_top kpi_asserts #(.NPINS(NPINS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pull_enable(port_pull_enable), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .deep_stop_wake(deep_stop_wake), .irq(irq)
);
`default_nettype wire

// >>> bench/kpi_keypad.sv
// Key switch model: a pressed key drives its pin to a commanded level, else the pull wins.
// Assumes pull outputs of the block; a pin with no pull and no key floats.
`default_nettype none
module kpi_keypad #(
    parameter NPINS = 8
) (
    // Clock and key commands
    input wire logic             pclk,
    input wire logic [NPINS-1:0] key_on,
    input wire logic [NPINS-1:0] key_lvl,
    // Pull control and pins
    input wire logic [NPINS-1:0] pull_up_en,
    input wire logic [NPINS-1:0] pull_down_en,
    output var logic [NPINS-1:0] pins
);
    // ****************************************************************
    // Pin level
    // ****************************************************************
    initial pins = '1;
    always @(posedge pclk) begin
        for (int i = 0; i < NPINS; i++) begin
            if (key_on[i])
                pins[i] <= key_lvl[i];
            else if (pull_up_en[i] | pull_down_en[i])
                pins[i] <= pull_up_en[i];
            else
                pins[i] <= ~pins[i]; // Floating: never a stable level to lean on
        end
    end
endmodule
`default_nettype wire

// >>> bench/kpi_tb.sv
// Bench for the keypad pin interrupt block: APB master tasks, key model, self-checking tests.
// Assumes kpi_top, kpi_keypad and the bound checker are compiled ahead of this file.
`include "kpi_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic                   pclk = 1'b0, presetn = 1'b0, dsw = 1'b0;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [`KPI_ADDR_W-1:0] paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0, prdata, rd;
    logic                   pready, pslverr, irq, err;
    logic [7:0]             key_on = 8'h00, key_lvl = 8'h00, pins, pu, pd;
    int                     failures = 0, checked = 0;
    always #5 pclk = ~pclk;
    kpi_top #(.NPINS(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .keypad_input_pins(pins), .port_pull_enable(8'hFF),
        .pull_up_en(pu), .pull_down_en(pd), .deep_stop_wake(dsw), .irq(irq)
    );
    kpi_keypad #(.NPINS(8)) u_keys (
        .pclk(pclk), .key_on(key_on), .key_lvl(key_lvl), .pull_up_en(pu), .pull_down_en(pd), .pins(pins)
    );
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits as long as it takes; only the watchdog ends a hung transfer
    task automatic apb(input logic wr, input logic [`KPI_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk(n, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [`KPI_ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic settle;
        repeat (10) @(posedge pclk);
    endtask
    // Pull enables are tied on from the start, so that step is already done
    task automatic setup_pins(input logic [7:0] pol, input logic [7:0] en, input logic mode);
        apb(1'b1, `KPI_OFS_STATUS, {31'h0, mode});
        apb(1'b1, `KPI_OFS_POLARITY, {24'h0, pol});
        apb(1'b1, `KPI_OFS_PIN_EN, {24'h0, en});
        settle;
        apb(1'b1, `KPI_OFS_STATUS, {29'h0, 2'b10, mode});
        apb(1'b1, `KPI_OFS_STATUS, {30'h0, 1'b1, mode});
        rdchk(`KPI_OFS_STATUS, {30'h0, 1'b1, mode});
    endtask
    task automatic t_regs;
        rdchk(`KPI_OFS_STATUS, 32'h0);
        rdchk(`KPI_OFS_PIN_EN, 32'h0);
        rdchk(`KPI_OFS_POLARITY, 32'h0);
        apb(1'b1, `KPI_OFS_STATUS, 32'hFFFFFFFF);
        rdchk(`KPI_OFS_STATUS, 32'h3);
        apb(1'b1, `KPI_OFS_STATUS, 32'h0);
        apb(1'b1, `KPI_OFS_PIN_EN, 32'hA5);
        apb(1'b1, `KPI_OFS_POLARITY, 32'hF0);
        rdchk(`KPI_OFS_PIN_EN, 32'hA5);
        rdchk(`KPI_OFS_POLARITY, 32'hF0);
        chk({24'h0, pd}, 32'hA0);
        chk({24'h0, pu}, 32'h5F);
        rdchk(12'h00C, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("register test done");
    endtask
    task automatic t_edge;
        setup_pins(8'h00, 8'hFF, 1'b0);
        key_on <= 8'h08;
        settle;
        chk({31'h0, irq}, 32'h1);
        rdchk(`KPI_OFS_STATUS, 32'hA);
        apb(1'b1, `KPI_OFS_STATUS, 32'h6);
        key_on <= 8'h28;
        settle;
        rdchk(`KPI_OFS_STATUS, 32'h2);
        key_on <= 8'h00;
        settle;
        key_on <= 8'h20;
        settle;
        rdchk(`KPI_OFS_STATUS, 32'hA);
        apb(1'b1, `KPI_OFS_STATUS, 32'h0);
        settle;
        chk({31'h0, irq}, 32'h0);
        rdchk(`KPI_OFS_STATUS, 32'h8);
        key_on <= 8'h00;
        $display("falling edge test done");
    endtask
    task automatic t_rise;
        setup_pins(8'hFF, 8'h0F, 1'b0);
        chk({24'h0, pd}, 32'h0F);
        chk({24'h0, pu}, 32'hF0);
        settle;
        rdchk(`KPI_OFS_STATUS, 32'h2);
        key_lvl <= 8'hFF;
        key_on <= 8'h01;
        settle;
        rdchk(`KPI_OFS_STATUS, 32'hA);
        key_on <= 8'h00;
        $display("rising edge test done");
    endtask
    task automatic t_level;
        setup_pins(8'h00, 8'hFF, 1'b1);
        key_lvl <= 8'h00;
        key_on <= 8'h04;
        settle;
        rdchk(`KPI_OFS_STATUS, 32'hB);
        apb(1'b1, `KPI_OFS_STATUS, 32'h7);
        settle;
        rdchk(`KPI_OFS_STATUS, 32'hB);
        key_on <= 8'h00;
        settle;
        apb(1'b1, `KPI_OFS_STATUS, 32'h7);
        rdchk(`KPI_OFS_STATUS, 32'h3);
        $display("level test done");
    endtask
    task automatic t_deep;
        key_on <= 8'h04;
        settle;
        chk({31'h0, irq}, 32'h1);
        dsw <= 1'b1;
        @(posedge pclk);
        dsw <= 1'b0;
        key_on <= 8'h00;
        settle;
        chk({31'h0, irq}, 32'h0);
        rdchk(`KPI_OFS_STATUS, 32'h0);
        rdchk(`KPI_OFS_PIN_EN, 32'h0);
        rdchk(`KPI_OFS_POLARITY, 32'h0);
        $display("deep stop test done");
    endtask
    task automatic close_out;
        $display("checked %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_edge;
        t_rise;
        t_level;
        t_deep;
        close_out;
    end
    initial begin
        #100us;
        failures++;
        close_out;
    end
endmodule
`default_nettype wire
